// >>> hdl/vsq_char_clock.v
// Dot and character clock enable generator with serializer load cadence.
`timescale 1ns/1ps
`default_nettype none
`include "vsq_regs.vh"
module vsq_char_clock (
	input  wire       core_clk,
	input  wire       rst,
	input  wire       half_dot_clock,
	input  wire       eight_dot_char_select,
	input  wire       serializer_load_every_second,
	input  wire       serializer_load_every_fourth,
	input  wire [8:0] horizontal_total,
	output reg        dot_enable_reg,
	output reg        char_enable_reg,
	output reg        load_enable_reg,
	output reg  [8:0] char_count_reg
);
	reg       half_phase_reg;
	reg [3:0] dot_count_reg;
	reg [1:0] load_phase_reg;
	wire      dot_tick;
	wire      char_tick;
	wire [3:0] dots_last;
	wire [8:0] line_last;

	assign dot_tick  = ~half_dot_clock | half_phase_reg;
	assign dots_last = eight_dot_char_select ? (`VSQ_DOTS_EIGHT - 4'd1) : (`VSQ_DOTS_NINE - 4'd1);
	assign char_tick = dot_tick && (dot_count_reg >= dots_last);
	assign line_last = horizontal_total + `VSQ_HTOTAL_OFFSET - 9'd1;

	always @(posedge core_clk) begin
		if (rst) begin
			half_phase_reg  <= 1'b0;
			dot_count_reg   <= 4'h0;
			load_phase_reg  <= 2'h0;
			char_count_reg  <= 9'h000;
			dot_enable_reg  <= 1'b0;
			char_enable_reg <= 1'b0;
			load_enable_reg <= 1'b0;
		end else begin
			half_phase_reg  <= ~half_phase_reg;
			dot_enable_reg  <= dot_tick;
			char_enable_reg <= char_tick;
			load_enable_reg <= 1'b0;
			if (dot_tick) begin
				dot_count_reg <= char_tick ? 4'h0 : dot_count_reg + 4'h1;
			end
			if (char_tick) begin
				load_phase_reg <= load_phase_reg + 2'h1;
				if (serializer_load_every_fourth) begin
					load_enable_reg <= (load_phase_reg == 2'h3);
				end else if (serializer_load_every_second) begin
					load_enable_reg <= load_phase_reg[0];
				end else begin
					load_enable_reg <= 1'b1;
				end
				char_count_reg <= (char_count_reg >= line_last) ? 9'h000 : char_count_reg + 9'h001;
			end
		end
	end
endmodule // vsq_char_clock
`default_nettype wire

// >>> hdl/vsq_register_port.v
// Indexed sequencer and timing-controller register port with CPU memory plane steering.
`timescale 1ns/1ps
`default_nettype none
`include "vsq_regs.vh"
module vsq_register_port #(
	parameter ADDR_WIDTH = 16,
	parameter MEM_ADDR_WIDTH = 18
) (
	input  wire                      core_clk,
	input  wire                      rst,
	input  wire                      io_write,
	input  wire                      io_read,
	input  wire [ADDR_WIDTH-1:0]     io_addr,
	input  wire [7:0]                io_wdata,
	input  wire                      mem_write,
	input  wire                      mem_read,
	input  wire [MEM_ADDR_WIDTH-1:0] mem_addr,
	input  wire                      text_mode,
	input  wire [7:0]                attribute_byte,
	output reg  [7:0]                io_rdata_reg,
	output reg                       io_hit_reg,
	output reg  [3:0]                plane_write_mask_reg,
	output reg  [3:0]                plane_read_select_reg,
	output reg  [MEM_ADDR_WIDTH-1:0] mem_plane_addr_reg,
	output reg                       mem_access_ok_reg,
	output reg  [2:0]                font_slot_reg,
	output reg                       foreground_bright_reg,
	output reg                       screen_blank_reg,
	output reg                       dot_enable_reg,
	output reg                       char_enable_reg,
	output reg                       serializer_load_reg,
	output reg  [8:0]                char_count_reg
);
	reg  [4:0] sequencer_index_port;
	reg  [7:0] sequencer_reset_control;
	reg  [7:0] clocking_mode;
	reg  [7:0] plane_write_enable;
	reg  [7:0] character_font_select;
	reg  [7:0] memory_mode_control;
	reg  [7:0] timing_ctrl_index_port;
	reg  [7:0] horizontal_total;
	reg        horizontal_overflow_extension;
	reg  [7:0] misc_output_reg;
	reg  [7:0] seq_read_next;
	reg  [7:0] io_read_next;
	reg        io_hit_next;
	reg  [3:0] plane_sel_next;
	reg  [MEM_ADDR_WIDTH-1:0] mem_addr_next;
	reg  [2:0] font_slot_next;
	wire       io_base_select;
	wire [ADDR_WIDTH-1:0] timing_index_addr;
	wire [ADDR_WIDTH-1:0] timing_data_addr;
	wire       extended_memory_enable;
	wire       sequential_addressing_select;
	wire       modulo_four_plane_addressing;
	wire [2:0] font_a_slot;
	wire [2:0] font_b_slot;
	wire [2:0] font_a_reach;
	wire [2:0] font_b_reach;
	wire       gen_dot;
	wire       gen_char;
	wire       gen_load;
	wire [8:0] gen_count;

	assign io_base_select    = misc_output_reg[`VSQ_BIT_IO_BASE];
	assign timing_index_addr = io_base_select ? `VSQ_IO_COLOR_INDEX : `VSQ_IO_MONO_INDEX;
	assign timing_data_addr  = io_base_select ? `VSQ_IO_COLOR_DATA : `VSQ_IO_MONO_DATA;
	assign extended_memory_enable       = memory_mode_control[`VSQ_BIT_EXT_MEMORY];
	assign sequential_addressing_select = memory_mode_control[`VSQ_BIT_SEQUENTIAL];
	assign modulo_four_plane_addressing = memory_mode_control[`VSQ_BIT_CHAIN_FOUR];
	assign font_b_slot  = {character_font_select[1:0], character_font_select[4]};
	assign font_a_slot  = {character_font_select[3:2], character_font_select[5]};
	assign font_b_reach = extended_memory_enable ? font_b_slot : {2'b00, font_b_slot[0]};
	assign font_a_reach = extended_memory_enable ? font_a_slot : {2'b00, font_a_slot[0]};

	vsq_char_clock u_char_clock (
		.core_clk                     (core_clk),
		.rst                          (rst),
		.half_dot_clock               (clocking_mode[`VSQ_BIT_HALF_DOT]),
		.eight_dot_char_select        (clocking_mode[`VSQ_BIT_EIGHT_DOT]),
		.serializer_load_every_second (clocking_mode[`VSQ_BIT_LOAD_SECOND]),
		.serializer_load_every_fourth (clocking_mode[`VSQ_BIT_LOAD_FOURTH]),
		.horizontal_total             ({horizontal_overflow_extension, horizontal_total}),
		.dot_enable_reg               (gen_dot),
		.char_enable_reg              (gen_char),
		.load_enable_reg              (gen_load),
		.char_count_reg               (gen_count)
	);

	always @* begin
		case (sequencer_index_port)
			`VSQ_SR_RESET_CONTROL: seq_read_next = sequencer_reset_control;
			`VSQ_SR_CLOCKING_MODE: seq_read_next = clocking_mode;
			`VSQ_SR_PLANE_WRITE:   seq_read_next = plane_write_enable;
			`VSQ_SR_FONT_SELECT:   seq_read_next = character_font_select;
			`VSQ_SR_MEMORY_MODE:   seq_read_next = memory_mode_control;
			default:               seq_read_next = 8'h00;
		endcase
	end

	always @* begin
		io_hit_next  = 1'b1;
		io_read_next = 8'h00;
		if (io_addr == `VSQ_IO_SEQ_INDEX) begin
			io_read_next = {3'b000, sequencer_index_port};
		end else if (io_addr == `VSQ_IO_SEQUENCER_DATA_PORT) begin
			io_read_next = seq_read_next;
		end else if (io_addr == `VSQ_IO_MISC_READ) begin
			io_read_next = misc_output_reg;
		end else if (io_addr == timing_index_addr) begin
			io_read_next = timing_ctrl_index_port;
		end else if (io_addr == timing_data_addr) begin
			if (timing_ctrl_index_port == `VSQ_CR_HORIZ_TOTAL) begin
				io_read_next = horizontal_total;
			end else if (timing_ctrl_index_port == `VSQ_CR_HORIZ_OVERFLOW) begin
				io_read_next = {7'h00, horizontal_overflow_extension};
			end
		end else begin
			io_hit_next = 1'b0;
		end
	end

	always @* begin
		mem_addr_next = mem_addr;
		if (modulo_four_plane_addressing) begin
			plane_sel_next = 4'h1 << mem_addr[1:0];
			mem_addr_next  = {2'b00, mem_addr[MEM_ADDR_WIDTH-1:2]};
		end else if (mem_write && sequential_addressing_select) begin
			plane_sel_next = 4'hf;
		end else begin
			plane_sel_next = mem_addr[0] ? 4'ha : 4'h5;
			mem_addr_next  = {mem_addr[MEM_ADDR_WIDTH-1:1], 1'b0};
		end
		if (!extended_memory_enable) begin
			mem_addr_next = mem_addr_next & {{(MEM_ADDR_WIDTH-15){1'b0}}, 15'h7fff};
		end
	end

	always @* begin
		if (text_mode && (font_a_reach != font_b_reach)) begin
			font_slot_next = attribute_byte[3] ? font_b_reach : font_a_reach;
		end else begin
			font_slot_next = font_a_reach;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			sequencer_index_port          <= 5'h00;
			sequencer_reset_control       <= `VSQ_SEQ_RESET_VALUE;
			clocking_mode                 <= `VSQ_SEQ_RESET_VALUE;
			plane_write_enable            <= `VSQ_SEQ_RESET_VALUE;
			character_font_select         <= `VSQ_SEQ_RESET_VALUE;
			memory_mode_control           <= `VSQ_SEQ_RESET_VALUE;
			timing_ctrl_index_port        <= `VSQ_CRTC_INDEX_RESET;
			horizontal_total              <= `VSQ_HTOTAL_RESET;
			horizontal_overflow_extension <= 1'b0;
			misc_output_reg               <= 8'h00;
		end else if (io_write) begin
			if (io_addr == `VSQ_IO_SEQ_INDEX) begin
				sequencer_index_port <= io_wdata[4:0];
			end else if (io_addr == `VSQ_IO_SEQUENCER_DATA_PORT) begin
				case (sequencer_index_port)
					`VSQ_SR_RESET_CONTROL: sequencer_reset_control <= io_wdata & `VSQ_RESET_CONTROL_MASK;
					`VSQ_SR_CLOCKING_MODE: clocking_mode <= io_wdata & `VSQ_CLOCKING_MODE_MASK;
					`VSQ_SR_PLANE_WRITE:   plane_write_enable <= io_wdata & `VSQ_PLANE_WRITE_MASK;
					`VSQ_SR_FONT_SELECT:   character_font_select <= io_wdata & `VSQ_FONT_SELECT_MASK;
					`VSQ_SR_MEMORY_MODE:   memory_mode_control <= io_wdata & `VSQ_MEMORY_MODE_MASK;
					default: ;
				endcase
			end else if (io_addr == `VSQ_IO_MISC_WRITE) begin
				misc_output_reg <= io_wdata;
			end else if (io_addr == timing_index_addr) begin
				timing_ctrl_index_port <= io_wdata;
			end else if (io_addr == timing_data_addr) begin
				if (timing_ctrl_index_port == `VSQ_CR_HORIZ_TOTAL) begin
					horizontal_total <= io_wdata;
				end else if (timing_ctrl_index_port == `VSQ_CR_HORIZ_OVERFLOW) begin
					horizontal_overflow_extension <= io_wdata[0];
				end
			end
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			io_rdata_reg          <= 8'h00;
			io_hit_reg            <= 1'b0;
			plane_write_mask_reg  <= 4'h0;
			plane_read_select_reg <= 4'h0;
			mem_plane_addr_reg    <= {MEM_ADDR_WIDTH{1'b0}};
			mem_access_ok_reg     <= 1'b0;
			font_slot_reg         <= 3'h0;
			foreground_bright_reg <= 1'b0;
			screen_blank_reg      <= 1'b1;
			dot_enable_reg        <= 1'b0;
			char_enable_reg       <= 1'b0;
			serializer_load_reg   <= 1'b0;
			char_count_reg        <= 9'h000;
		end else begin
			io_rdata_reg          <= io_read ? io_read_next : 8'h00;
			io_hit_reg            <= (io_read | io_write) & io_hit_next;
			plane_write_mask_reg  <= mem_write ? (plane_sel_next & plane_write_enable[3:0]) : 4'h0;
			plane_read_select_reg <= mem_read ? plane_sel_next : 4'h0;
			mem_plane_addr_reg    <= mem_addr_next;
			mem_access_ok_reg     <= (mem_read | mem_write) & (extended_memory_enable | (mem_addr[MEM_ADDR_WIDTH-1:15] == {(MEM_ADDR_WIDTH-15){1'b0}}));
			font_slot_reg         <= font_slot_next;
			foreground_bright_reg <= attribute_byte[3] & ~(text_mode && (font_a_reach != font_b_reach));
			screen_blank_reg      <= clocking_mode[`VSQ_BIT_SCREEN_BLANK];
			dot_enable_reg        <= gen_dot;
			char_enable_reg       <= gen_char;
			serializer_load_reg   <= gen_load;
			char_count_reg        <= gen_count;
		end
	end
endmodule // vsq_register_port
`default_nettype wire

// >>> hdl/vsq_regs.vh
// Offsets, field positions, reset values and timing figures of the sequencer register port.
`ifndef VSQ_REGS_VH
`define VSQ_REGS_VH
`define VSQ_IO_SEQ_INDEX      16'h03c4
`define VSQ_IO_SEQUENCER_DATA_PORT       16'h03c5
`define VSQ_IO_MISC_WRITE     16'h03c2
`define VSQ_IO_MISC_READ      16'h03cc
`define VSQ_IO_MONO_INDEX     16'h03b4
`define VSQ_IO_MONO_DATA      16'h03b5
`define VSQ_IO_COLOR_INDEX    16'h03d4
`define VSQ_IO_COLOR_DATA     16'h03d5
`define VSQ_SR_RESET_CONTROL  5'h00
`define VSQ_SR_CLOCKING_MODE  5'h01
`define VSQ_SR_PLANE_WRITE    5'h02
`define VSQ_SR_FONT_SELECT    5'h03
`define VSQ_SR_MEMORY_MODE    5'h04
`define VSQ_CR_HORIZ_TOTAL    8'h00
`define VSQ_CR_HORIZ_OVERFLOW 8'h5d
`define VSQ_RESET_CONTROL_MASK 8'h03
`define VSQ_CLOCKING_MODE_MASK 8'h3d
`define VSQ_PLANE_WRITE_MASK   8'h0f
`define VSQ_FONT_SELECT_MASK   8'h3f
`define VSQ_MEMORY_MODE_MASK   8'h0e
`define VSQ_SEQ_RESET_VALUE    8'h00
`define VSQ_CRTC_INDEX_RESET   8'h00
`define VSQ_HTOTAL_RESET       8'h00
`define VSQ_BIT_EIGHT_DOT      0
`define VSQ_BIT_LOAD_SECOND    2
`define VSQ_BIT_HALF_DOT       3
`define VSQ_BIT_LOAD_FOURTH    4
`define VSQ_BIT_SCREEN_BLANK   5
`define VSQ_BIT_EXT_MEMORY     1
`define VSQ_BIT_SEQUENTIAL     2
`define VSQ_BIT_CHAIN_FOUR     3
`define VSQ_BIT_IO_BASE        0
`define VSQ_HTOTAL_OFFSET      9'd5
`define VSQ_DOTS_NINE          4'd9
`define VSQ_DOTS_EIGHT         4'd8
`endif

// >>> verif/tb_vsq_register_port.sv
// Self-checking testbench of the sequencer register port.
`timescale 1ns/1ps
`default_nettype none
`include "vsq_regs.vh"
module tb_vsq_register_port;
	logic        core_clk, rst, mem_write, mem_read, text_mode, sel_ld, h;
	logic [17:0] mem_addr;
	logic [7:0]  attribute_byte, io_rdata_reg, io_wdata, d;
	logic [15:0] io_addr;
	logic        io_write, io_read, io_hit_reg, mem_access_ok_reg, foreground_bright_reg, screen_blank_reg;
	logic        dot_enable_reg, char_enable_reg, serializer_load_reg;
	logic [3:0]  plane_write_mask_reg, plane_read_select_reg;
	logic [17:0] mem_plane_addr_reg;
	logic [2:0]  font_slot_reg;
	logic [8:0]  char_count_reg, top;
	int          failures, comparisons, n;
	logic [23:0] rows [6] = '{24'h00ff03, 24'h01ff3d, 24'h02ff0f, 24'h03ff3f, 24'h04ff0e, 24'h05ff00};
	wire pulse = sel_ld ? serializer_load_reg : char_enable_reg;
	vsq_host_model host_u (.core_clk(core_clk), .io_rdata_reg(io_rdata_reg), .io_hit_reg(io_hit_reg),
		.io_write(io_write), .io_read(io_read), .io_addr(io_addr), .io_wdata(io_wdata));
	vsq_register_port dut_u (.core_clk(core_clk), .rst(rst), .io_write(io_write), .io_read(io_read),
		.io_addr(io_addr), .io_wdata(io_wdata), .mem_write(mem_write), .mem_read(mem_read), .mem_addr(mem_addr),
		.text_mode(text_mode), .attribute_byte(attribute_byte), .io_rdata_reg(io_rdata_reg),
		.io_hit_reg(io_hit_reg), .plane_write_mask_reg(plane_write_mask_reg),
		.plane_read_select_reg(plane_read_select_reg), .mem_plane_addr_reg(mem_plane_addr_reg),
		.mem_access_ok_reg(mem_access_ok_reg), .font_slot_reg(font_slot_reg),
		.foreground_bright_reg(foreground_bright_reg), .screen_blank_reg(screen_blank_reg),
		.dot_enable_reg(dot_enable_reg), .char_enable_reg(char_enable_reg),
		.serializer_load_reg(serializer_load_reg), .char_count_reg(char_count_reg));
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task end_sim;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [17:0] got, input logic [17:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task step(input logic [15:0] a, input logic [7:0] v);
		host_u.wr(a - 16'h0001, v[7] ? 8'h5d : 8'h00);
		host_u.wr(a, v);
	endtask
	task sreg(input logic [7:0] i, input logic [7:0] v);
		host_u.wr(`VSQ_IO_SEQ_INDEX, i);
		host_u.wr(`VSQ_IO_SEQUENCER_DATA_PORT, v);
	endtask
	task to_pulse;
		n = 0;
		do begin
			@(posedge core_clk); #1;
			n++;
			if (n > 600) begin
				failures++;
				end_sim;
			end
		end while (pulse !== 1'b1);
	endtask
	task gap(input logic ld, input logic [8:0] exp);
		sel_ld = ld;
		to_pulse;
		to_pulse;
		to_pulse;
		chk(n, exp);
	endtask
	task mem(input logic w, input logic [17:0] a);
		mem_write = w;
		mem_read = !w;
		mem_addr = a;
		@(posedge core_clk); #1;
		mem_write = 1'b0;
		mem_read = 1'b0;
		mem_addr = ~a;
	endtask
	initial begin
		{rst, mem_write, mem_read, text_mode, sel_ld} = 5'b10000;
		mem_addr = 18'h00000;
		attribute_byte = 8'h00;
		repeat (2) @(posedge core_clk);
		#1;
		chk(screen_blank_reg, 1'b1);
		rst = 1'b0;
		for (int i = 0; i < 5; i++) begin
			host_u.wr(`VSQ_IO_SEQ_INDEX, i[7:0]);
			host_u.rd(`VSQ_IO_SEQUENCER_DATA_PORT, d, h);
			chk(d, 8'h00);
		end
		host_u.rd(`VSQ_IO_MONO_INDEX, d, h);
		chk({h, d}, 9'h100);
		for (int i = 0; i < 6; i++) begin
			sreg({3'b111, rows[i][20:16]}, rows[i][15:8]);
			host_u.rd(`VSQ_IO_SEQUENCER_DATA_PORT, d, h);
			chk({h, d}, {1'b1, rows[i][7:0]});
			host_u.rd(`VSQ_IO_SEQ_INDEX, d, h);
			chk(d, rows[i][23:16]);
		end
		chk(screen_blank_reg, 1'b1);
		for (int i = 0; i < 4; i++) begin
			mem(1'b1, i);
			chk(plane_write_mask_reg, 4'h1 << i);
		end
		mem(1'b0, 18'h00007);
		chk(plane_read_select_reg, 4'h8);
		chk(mem_plane_addr_reg, 18'h00001);
		sreg(8'h04, 8'h02);
		mem(1'b1, 18'h00004);
		chk(plane_write_mask_reg, 4'h5);
		mem(1'b1, 18'h00005);
		chk(plane_write_mask_reg, 4'ha);
		chk(mem_plane_addr_reg, 18'h00004);
		sreg(8'h04, 8'h06);
		mem(1'b1, 18'h00005);
		chk(plane_write_mask_reg, 4'hf);
		mem(1'b0, 18'h00005);
		chk(plane_read_select_reg, 4'ha);
		sreg(8'h02, 8'h05);
		sreg(8'h04, 8'h08);
		mem(1'b1, 18'h00002);
		chk(plane_write_mask_reg, 4'h4);
		mem(1'b1, 18'h00001);
		chk(plane_write_mask_reg, 4'h0);
		sreg(8'h04, 8'h00);
		mem(1'b0, 18'h10000);
		chk(mem_access_ok_reg, 1'b0);
		chk(mem_plane_addr_reg, 18'h00000);
		sreg(8'h04, 8'h02);
		mem(1'b0, 18'h10000);
		chk(mem_access_ok_reg, 1'b1);
		sreg(8'h03, 8'h27);
		text_mode = 1'b1;
		for (int i = 0; i < 3; i++) begin
			if (i == 2)
				sreg(8'h03, 8'h00);
			attribute_byte = (i == 1) ? 8'h00 : 8'h08;
			repeat (2) @(posedge core_clk);
			#1;
			chk({foreground_bright_reg, font_slot_reg}, (i == 0) ? 4'h6 : (i == 1) ? 4'h3 : 4'h8);
		end
		sreg(8'h03, 8'h27);
		sreg(8'h04, 8'h00);
		attribute_byte = 8'h00;
		repeat (2) @(posedge core_clk);
		#1;
		chk({foreground_bright_reg, font_slot_reg}, 4'h1);
		attribute_byte = 8'h08;
		repeat (2) @(posedge core_clk);
		#1;
		chk({foreground_bright_reg, font_slot_reg}, 4'h0);
		sreg(8'h01, 8'h01);
		@(posedge core_clk); #1;
		chk(screen_blank_reg, 1'b0);
		gap(1'b0, 9'd8);
		gap(1'b1, 9'd8);
		sreg(8'h01, 8'h00);
		gap(1'b0, 9'd9);
		sreg(8'h01, 8'h09);
		gap(1'b0, 9'd16);
		h = dot_enable_reg;
		@(posedge core_clk); #1;
		chk(dot_enable_reg, !h);
		sreg(8'h01, 8'h05);
		gap(1'b1, 9'd16);
		sreg(8'h01, 8'h11);
		gap(1'b1, 9'd32);
		sreg(8'h01, 8'h01);
		step(`VSQ_IO_MONO_DATA, 8'h03);
		step(`VSQ_IO_MONO_DATA, 8'h81);
		host_u.rd(`VSQ_IO_MONO_DATA, d, h);
		chk(d, 8'h01);
		chk(dot_enable_reg, 1'b1);
		host_u.rd(`VSQ_IO_COLOR_DATA, d, h);
		chk(h, 1'b0);
		host_u.wr(`VSQ_IO_MISC_WRITE, 8'h01);
		host_u.rd(`VSQ_IO_COLOR_INDEX, d, h);
		chk({h, d}, 9'h15d);
		host_u.rd(16'h0300, d, h);
		chk({h, d}, 9'h000);
		top = 9'h000;
		n = 0;
		while (char_count_reg !== 9'h000 && n < 5000) begin
			@(posedge core_clk); #1;
			n++;
		end
		while (char_count_reg === 9'h000 && n < 5000) begin
			@(posedge core_clk); #1;
			n++;
		end
		do begin
			@(posedge core_clk); #1;
			n++;
			if (char_count_reg > top)
				top = char_count_reg;
		end while (char_count_reg !== 9'h000 && n < 9000);
		chk(top, 9'd263);
		chk(n < 9000, 1'b1);
		end_sim;
	end
endmodule // tb_vsq_register_port
`default_nettype wire

// >>> verif/vsq_host_model.sv
// Host processor model issuing I/O port writes and reads.
`timescale 1ns/1ps
`default_nettype none
module vsq_host_model (
	input  wire logic        core_clk,
	input  wire logic [7:0]  io_rdata_reg,
	input  wire logic        io_hit_reg,
	output var  logic        io_write,
	output var  logic        io_read,
	output var  logic [15:0] io_addr,
	output var  logic [7:0]  io_wdata
);
	initial begin
		io_write = 1'b0;
		io_read = 1'b0;
		io_addr = 16'h0000;
		io_wdata = 8'h00;
	end
	// Each write drives one port address for one clock; any index write is left to the caller.
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk); #1;
		io_write = 1'b1;
		io_addr = a;
		io_wdata = d;
		@(posedge core_clk); #1;
		io_write = 1'b0;
		io_wdata = ~d;
	endtask
	task rd(input logic [15:0] a, output logic [7:0] d, output logic h);
		@(posedge core_clk); #1;
		io_read = 1'b1;
		io_addr = a;
		@(posedge core_clk); #1;
		io_read = 1'b0;
		d = io_rdata_reg;
		h = io_hit_reg;
	endtask
endmodule // vsq_host_model
`default_nettype wire

// >>> verif/vsq_register_port_properties.sv
// Checker of the sequencer register port, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
`include "vsq_regs.vh"
module vsq_register_port_properties #(
	parameter ADDR_WIDTH     = 16,
	parameter MEM_ADDR_WIDTH = 18
) (
	input wire logic                      core_clk,
	input wire logic                      rst,
	input wire logic                      io_write,
	input wire logic                      io_read,
	input wire logic [ADDR_WIDTH-1:0]     io_addr,
	input wire logic                      mem_write,
	input wire logic                      mem_read,
	input wire logic [MEM_ADDR_WIDTH-1:0] mem_addr,
	input wire logic [7:0]                attribute_byte,
	input wire logic [7:0]                io_rdata_reg,
	input wire logic                      io_hit_reg,
	input wire logic [3:0]                plane_write_mask_reg,
	input wire logic                      mem_access_ok_reg,
	input wire logic                      foreground_bright_reg,
	input wire logic                      screen_blank_reg,
	input wire logic                      char_enable_reg,
	input wire logic [8:0]                char_count_reg
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_hit_after_req: assert property (io_hit_reg |-> $past(io_read || io_write))
		else $error("hit without a request");
	a_seq_index_hit: assert property (io_read && io_addr == `VSQ_IO_SEQ_INDEX |=> io_hit_reg)
		else $error("index read not decoded");
	a_idle_read_zero: assert property (!io_read |=> io_rdata_reg == 8'h00)
		else $error("read data without a read");
	a_index_reserved: assert property (io_read && io_addr == `VSQ_IO_SEQ_INDEX |=> io_rdata_reg[7:5] == 3'h0)
		else $error("index reserved bits set");
	a_blank_in_reset: assert property (disable iff (1'b0) $past(rst) |-> screen_blank_reg)
		else $error("screen not blank in reset");
	a_mask_needs_write: assert property (!mem_write |=> plane_write_mask_reg == 4'h0)
		else $error("plane write without a write");
	a_low_access_ok: assert property ((mem_read || mem_write) && mem_addr < 18'h08000 |=> mem_access_ok_reg)
		else $error("low access refused");
	a_count_step: assert property ($changed(char_count_reg) |-> char_count_reg == 9'h000 ||
		char_count_reg == $past(char_count_reg) + 9'h001)
		else $error("character counter jumped");
	a_char_spacing: assert property (char_enable_reg |=> !char_enable_reg [*7])
		else $error("character clock narrower than eight dots");
	a_bright_source: assert property (foreground_bright_reg |-> $past(attribute_byte[3]))
		else $error("intensity without attribute bit");
endmodule // vsq_register_port_properties
bind vsq_register_port vsq_register_port_properties #(.ADDR_WIDTH(ADDR_WIDTH), .MEM_ADDR_WIDTH(MEM_ADDR_WIDTH)) chk_u (
	.core_clk(core_clk), .rst(rst), .io_write(io_write), .io_read(io_read), .io_addr(io_addr),
	.mem_write(mem_write), .mem_read(mem_read), .mem_addr(mem_addr), .attribute_byte(attribute_byte),
	.io_rdata_reg(io_rdata_reg), .io_hit_reg(io_hit_reg), .plane_write_mask_reg(plane_write_mask_reg),
	.mem_access_ok_reg(mem_access_ok_reg), .foreground_bright_reg(foreground_bright_reg),
	.screen_blank_reg(screen_blank_reg), .char_enable_reg(char_enable_reg), .char_count_reg(char_count_reg));
`default_nettype wire
